// >>> rtl/periph_irq_flag_regs.sv
// Peripheral interrupt flag registers behind an Avalon-MM slave port
//
// Notes on behaviour
// - Flags set on their events; no enable, local or global, gates them.
// - Converter-done flag, first register bit 6, sets on completion, sticky.
// - Receive-full flag, bit 5, read-only, shows buffer occupied, read clears.
// - Transmit-empty flag, bit 4, read-only, shows buffer empty, write clears.
// - Capture mode: capture/compare flag bit 2 sets on capture, sticky.
// - Compare mode: capture/compare flag sets on compare match, sticky.
// - PWM mode: capture/compare flag is never set by hardware.
// - Period-match flag bit 1 sets when second timer equals period, sticky.
// - Timer-overflow flag bit 0 sets on first timer overflow, sticky.
// - Oscillator-fail flag, second register bit 7, sets on failover, sticky.
// - Unimplemented bits read zero; implemented bits reset to zero.
`include "pirq_defines.svh"

module periph_irq_flag_regs (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Avalon-MM slave
  input  wire logic [4:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  // Event pulses from peripheral units on the same clock
  input  wire logic                conv_done_event,
  input  wire logic                rx_load,
  input  wire logic [7:0]          rx_byte,
  input  wire logic                tx_buf_free,
  input  wire logic                capture_event,
  input  wire logic                compare_match,
  input  wire logic                period_match_event,
  input  wire logic                timer_overflow_event,
  input  wire logic                osc_fail_event,
  input  wire logic                usb_request,
  input  wire logic                voltage_event,
  // Toward peripheral units and the interrupt logic
  output logic      [7:0]          tx_byte,
  output logic                     tx_pending,
  output pirq_pkg::capcmp_mode_type capcmp_mode,
  output logic      [7:0]          flag_reg_one,
  output logic      [7:0]          flag_reg_two
);
  import pirq_pkg::*;

  // ==========================================================================
  // Slave port handshake
  bus_state_type   bus_state_r;
  bus_state_type   bus_state_nxt;
  logic            waitreq_r;
  logic            waitreq_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;
  logic [31:0]     read_mux;
  logic            ack;
  logic            wr_lane0;
  logic            wr_one;
  logic            wr_two;
  logic            wr_ctrl;
  logic            wr_tx;
  logic            rd_rx;

  // ==========================================================================
  // Buffer-tracking flags and control
  logic            rx_full_r;
  logic            rx_full_nxt;
  logic [7:0]      rx_data_r;
  logic [7:0]      rx_data_nxt;
  logic            tx_empty_r;
  logic            tx_empty_nxt;
  logic [7:0]      tx_byte_r;
  logic [7:0]      tx_byte_nxt;
  logic            tx_pending_r;
  logic            tx_pending_nxt;
  capcmp_mode_type mode_r;
  capcmp_mode_type mode_nxt;
  logic            capcmp_hit;

  sticky_flag_if   flags ();

  sticky_flag_bank u_bank (
    .core_clk (core_clk),
    .nrst     (nrst),
    .flags    (flags)
  );

  // ==========================================================================
  // Register views
  always_comb begin
    flag_reg_one = {1'b0,
                    flags.q[`IDX_CONV_DONE],
                    rx_full_r,
                    tx_empty_r,
                    1'b0,
                    flags.q[`IDX_CAPCMP],
                    flags.q[`IDX_PERIOD_MATCH],
                    flags.q[`IDX_TIMER_OVF]};
    flag_reg_two = {flags.q[`IDX_OSC_FAIL],
                    1'b0,
                    flags.q[`IDX_USB_EVENT],
                    2'b00,
                    flags.q[`IDX_VOLT_DETECT],
                    2'b00};
  end

  always_comb begin
    unique case (avs_address)
      `OFS_FLAG_ONE:    read_mux = {24'h00_0000, flag_reg_one};
      `OFS_FLAG_TWO:    read_mux = {24'h00_0000, flag_reg_two};
      `OFS_RX_BUFFER:   read_mux = {24'h00_0000, rx_data_r};
      `OFS_TX_BUFFER:   read_mux = {24'h00_0000, tx_byte_r};
      `OFS_CAPCMP_CTRL: read_mux = {30'h0000_0000, mode_r};
      default:          read_mux = `RST_WORD;
    endcase
  end

  // ==========================================================================
  // Handshake: one wait cycle, then a single answer cycle. Side effects land
  // on the answer edge, the same edge at which the master takes the answer.
  always_comb begin
    bus_state_nxt = bus_state_r;
    waitreq_nxt   = 1'b1;
    rdata_nxt     = rdata_r;
    unique case (bus_state_r)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_state_nxt = BUS_ACK;
          waitreq_nxt   = 1'b0;
          rdata_nxt     = avs_read ? read_mux : `RST_WORD;
        end
      end
      BUS_ACK: begin
        bus_state_nxt = BUS_IDLE;
        rdata_nxt     = `RST_WORD;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_r <= BUS_IDLE;
      waitreq_r   <= 1'b1;
      rdata_r     <= `RST_WORD;
    end else begin
      bus_state_r <= bus_state_nxt;
      waitreq_r   <= waitreq_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  always_comb begin
    ack      = (bus_state_r == BUS_ACK);
    // Only the low byte lane holds data; other lanes are ignored
    wr_lane0 = ack && avs_write && avs_byteenable[0];
    wr_one   = wr_lane0 && (avs_address == `OFS_FLAG_ONE);
    wr_two   = wr_lane0 && (avs_address == `OFS_FLAG_TWO);
    wr_ctrl  = wr_lane0 && (avs_address == `OFS_CAPCMP_CTRL);
    wr_tx    = wr_lane0 && (avs_address == `OFS_TX_BUFFER);
    rd_rx    = ack && avs_read && (avs_address == `OFS_RX_BUFFER);
  end

  // ==========================================================================
  // Sticky flags: events set regardless of any enable, software writes
  always_comb begin
    // PWM and off modes raise nothing on this flag
    capcmp_hit = ((mode_r == CC_CAPTURE) && capture_event)
               | ((mode_r == CC_COMPARE) && compare_match);

    flags.set                    = 7'h00;
    flags.set[`IDX_TIMER_OVF]    = timer_overflow_event;
    flags.set[`IDX_PERIOD_MATCH] = period_match_event;
    flags.set[`IDX_CAPCMP]       = capcmp_hit;
    flags.set[`IDX_CONV_DONE]    = conv_done_event;
    flags.set[`IDX_VOLT_DETECT]  = voltage_event;
    flags.set[`IDX_USB_EVENT]    = usb_request;
    flags.set[`IDX_OSC_FAIL]     = osc_fail_event;

    flags.wr                       = 7'h00;
    flags.wr[`IDX_TIMER_OVF]       = wr_one;
    flags.wr[`IDX_PERIOD_MATCH]    = wr_one;
    flags.wr[`IDX_CAPCMP]          = wr_one;
    flags.wr[`IDX_CONV_DONE]       = wr_one;
    flags.wr[`IDX_VOLT_DETECT]     = wr_two;
    flags.wr[`IDX_USB_EVENT]       = wr_two;
    flags.wr[`IDX_OSC_FAIL]        = wr_two;

    flags.wdata                    = 7'h00;
    flags.wdata[`IDX_TIMER_OVF]    = avs_writedata[`BIT_TIMER_OVF];
    flags.wdata[`IDX_PERIOD_MATCH] = avs_writedata[`BIT_PERIOD_MATCH];
    flags.wdata[`IDX_CAPCMP]       = avs_writedata[`BIT_CAPCMP];
    flags.wdata[`IDX_CONV_DONE]    = avs_writedata[`BIT_CONV_DONE];
    flags.wdata[`IDX_VOLT_DETECT]  = avs_writedata[`BIT_VOLT_DETECT];
    flags.wdata[`IDX_USB_EVENT]    = avs_writedata[`BIT_USB_EVENT];
    flags.wdata[`IDX_OSC_FAIL]     = avs_writedata[`BIT_OSC_FAIL];
  end

  // ==========================================================================
  // Buffer-tracking flags are read-only; they follow buffer access
  always_comb begin
    rx_data_nxt    = rx_load ? rx_byte : rx_data_r;
    // A byte arriving on the clearing read keeps the flag up
    rx_full_nxt    = rx_load | (rd_rx ? 1'b0 : rx_full_r);
    tx_byte_nxt    = wr_tx ? avs_writedata[7:0] : tx_byte_r;
    tx_empty_nxt   = tx_buf_free | (wr_tx ? 1'b0 : tx_empty_r);
    tx_pending_nxt = wr_tx | (tx_buf_free ? 1'b0 : tx_pending_r);
    mode_nxt       = wr_ctrl ? capcmp_mode_type'(avs_writedata[1:0]) : mode_r;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_full_r    <= 1'b0;
      rx_data_r    <= `RST_BYTE;
      tx_empty_r   <= 1'b0;
      tx_byte_r    <= `RST_BYTE;
      tx_pending_r <= 1'b0;
      mode_r       <= CC_OFF;
    end else begin
      rx_full_r    <= rx_full_nxt;
      rx_data_r    <= rx_data_nxt;
      tx_empty_r   <= tx_empty_nxt;
      tx_byte_r    <= tx_byte_nxt;
      tx_pending_r <= tx_pending_nxt;
      mode_r       <= mode_nxt;
    end
  end

  always_comb begin
    avs_readdata    = rdata_r;
    avs_waitrequest = waitreq_r;
    tx_byte         = tx_byte_r;
    tx_pending      = tx_pending_r;
    capcmp_mode     = mode_r;
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  AST_CONV_SET: assert property (conv_done_event |=> flag_reg_one[`BIT_CONV_DONE])
    else $error("converter-done flag not set after completion");

  AST_CONV_HOLD: assert property (flag_reg_one[`BIT_CONV_DONE] && !wr_one |=> flag_reg_one[`BIT_CONV_DONE])
    else $error("converter-done flag dropped without software write");

  AST_RX_SET: assert property (rx_load |=> rx_full_r && rx_data_r == $past(rx_byte))
    else $error("receive-full flag or data wrong after load");

  AST_RX_CLR: assert property (rd_rx && !rx_load |=> !rx_full_r)
    else $error("receive-full flag not cleared by buffer read");

  AST_TX_CLR: assert property (wr_tx && !tx_buf_free |=> !tx_empty_r && tx_pending_r)
    else $error("transmit-empty flag not cleared by buffer write");

  AST_TX_SET: assert property (tx_buf_free |=> tx_empty_r)
    else $error("transmit-empty flag not set when buffer frees");

  AST_CAPTURE: assert property (mode_r == CC_CAPTURE && capture_event |=> flag_reg_one[`BIT_CAPCMP])
    else $error("capture did not set capture/compare flag");

  AST_COMPARE: assert property (mode_r == CC_COMPARE && compare_match |=> flag_reg_one[`BIT_CAPCMP])
    else $error("compare match did not set capture/compare flag");

  AST_PWM_QUIET: assert property (mode_r == CC_PWM && !wr_one && !flag_reg_one[`BIT_CAPCMP]
                                  |=> !flag_reg_one[`BIT_CAPCMP])
    else $error("capture/compare flag rose in PWM mode");

  AST_PERIOD: assert property (period_match_event |=> flag_reg_one[`BIT_PERIOD_MATCH])
    else $error("period-match flag not set");

  AST_OVERFLOW: assert property (timer_overflow_event |=> flag_reg_one[`BIT_TIMER_OVF])
    else $error("timer-overflow flag not set");

  AST_OSC_FAIL: assert property (osc_fail_event |=> flag_reg_two[`BIT_OSC_FAIL])
    else $error("oscillator-fail flag not set");

  AST_USB: assert property (usb_request |=> flag_reg_two[`BIT_USB_EVENT])
    else $error("USB flag not set");

  AST_ZERO_BITS: assert property (ack && avs_read && avs_address == `OFS_FLAG_TWO
                                  |-> avs_readdata[6] == 1'b0 && avs_readdata[4:3] == 2'b00
                                      && avs_readdata[1:0] == 2'b00 && avs_readdata[31:8] == 24'h00_0000)
    else $error("unimplemented bits of second flag register not zero");

  AST_SET_WINS: assert property (timer_overflow_event && wr_one && !avs_writedata[`BIT_TIMER_OVF]
                                 |=> flag_reg_one[`BIT_TIMER_OVF])
    else $error("clearing write lost a simultaneous event");

  AST_ANSWER: assert property (bus_state_r == BUS_IDLE && (avs_read || avs_write)
                               |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("slave answer not exactly one cycle after request");

  // A flag moves only on its own event, a write to its own register or, for the buffer flags, a buffer access; holding is
  // checked apart from setting so that a bank that drops a flag on its own is caught too
  AST_CAPCMP_HOLD: assert property (flag_reg_one[`BIT_CAPCMP] && !wr_one |=> flag_reg_one[`BIT_CAPCMP])
    else $error("capture/compare flag dropped without software write");

  AST_PERIOD_HOLD: assert property (flag_reg_one[`BIT_PERIOD_MATCH] && !wr_one
                                    |=> flag_reg_one[`BIT_PERIOD_MATCH])
    else $error("period-match flag dropped without software write");

  AST_OVF_HOLD: assert property (flag_reg_one[`BIT_TIMER_OVF] && !wr_one |=> flag_reg_one[`BIT_TIMER_OVF])
    else $error("timer-overflow flag dropped without software write");

  AST_OSC_HOLD: assert property (flag_reg_two[`BIT_OSC_FAIL] && !wr_two |=> flag_reg_two[`BIT_OSC_FAIL])
    else $error("oscillator-fail flag dropped without software write");

  AST_USB_HOLD: assert property (flag_reg_two[`BIT_USB_EVENT] && !wr_two |=> flag_reg_two[`BIT_USB_EVENT])
    else $error("USB flag dropped without software write");

  AST_RX_HOLD: assert property (rx_full_r && !rd_rx |=> rx_full_r)
    else $error("receive-full flag dropped without buffer read");

  AST_TX_HOLD: assert property (tx_empty_r && !wr_tx |=> tx_empty_r)
    else $error("transmit-empty flag dropped without buffer write");

  AST_ZERO_ONE: assert property (ack && avs_read && avs_address == `OFS_FLAG_ONE
                                 |-> avs_readdata[7] == 1'b0 && avs_readdata[3] == 1'b0
                                     && avs_readdata[31:8] == 24'h00_0000)
    else $error("unimplemented bits of first flag register not zero");

  AST_OVF_CLEAR: assert property (wr_one && !timer_overflow_event && !avs_writedata[`BIT_TIMER_OVF]
                                  |=> !flag_reg_one[`BIT_TIMER_OVF])
    else $error("timer-overflow flag not cleared by software write");

  AST_CONV_CLEAR: assert property (wr_one && !conv_done_event && !avs_writedata[`BIT_CONV_DONE]
                                   |=> !flag_reg_one[`BIT_CONV_DONE])
    else $error("converter-done flag not cleared by software write");

  AST_OSC_CLEAR: assert property (wr_two && !osc_fail_event && !avs_writedata[`BIT_OSC_FAIL]
                                  |=> !flag_reg_two[`BIT_OSC_FAIL])
    else $error("oscillator-fail flag not cleared by software write");

  AST_OFF_QUIET: assert property (mode_r == CC_OFF && !wr_one && !flag_reg_one[`BIT_CAPCMP]
                                  |=> !flag_reg_one[`BIT_CAPCMP])
    else $error("capture/compare flag rose with the unit off");

  COV_CLEAR_ONE: cover property (ack && wr_one ##1 flag_reg_one == 8'h00);
  COV_RX_ROUND: cover property (rx_load ##[1:20] rd_rx);
  COV_COMPARE: cover property (mode_r == CC_COMPARE && compare_match);
  COV_SET_WINS: cover property (usb_request && wr_two && !avs_writedata[`BIT_USB_EVENT]);
  COV_PWM_IGNORED: cover property (mode_r == CC_PWM && compare_match);

endmodule

// >>> rtl/pirq_defines.svh
// Offsets, field positions, flag indexes and reset values for the peripheral flag block
`ifndef PIRQ_DEFINES_SVH
`define PIRQ_DEFINES_SVH

// ==========================================================================
// Register byte offsets on the slave port
`define OFS_FLAG_ONE     5'h00
`define OFS_FLAG_TWO     5'h04
`define OFS_RX_BUFFER    5'h08
`define OFS_TX_BUFFER    5'h0c
`define OFS_CAPCMP_CTRL  5'h10

// ==========================================================================
// Bit positions inside the two flag registers
`define BIT_TIMER_OVF    0
`define BIT_PERIOD_MATCH 1
`define BIT_CAPCMP       2
`define BIT_TX_EMPTY     4
`define BIT_RX_FULL      5
`define BIT_CONV_DONE    6
`define BIT_VOLT_DETECT  2
`define BIT_USB_EVENT    5
`define BIT_OSC_FAIL     7

// ==========================================================================
// Index of each sticky flag inside the flag bank
`define STICKY_COUNT     7
`define IDX_TIMER_OVF    0
`define IDX_PERIOD_MATCH 1
`define IDX_CAPCMP       2
`define IDX_CONV_DONE    3
`define IDX_VOLT_DETECT  4
`define IDX_USB_EVENT    5
`define IDX_OSC_FAIL     6

// ==========================================================================
// Reset values
`define RST_STICKY       7'h00
`define RST_BYTE         8'h00
`define RST_WORD         32'h0000_0000

`endif

// >>> rtl/pirq_pkg.sv
// Types shared by the peripheral flag block
package pirq_pkg;

  // Capture/compare unit operating mode, as programmed by software
  typedef enum logic [1:0] {
    CC_OFF     = 2'b00,
    CC_CAPTURE = 2'b01,
    CC_COMPARE = 2'b11,
    CC_PWM     = 2'b10
  } capcmp_mode_type;

  // Slave port handshake state
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_type;

endpackage

// >>> rtl/sticky_flag_if.sv
// Carrier between the register block and its sticky flag bank
interface sticky_flag_if;
  logic [6:0] set;
  logic [6:0] wr;
  logic [6:0] wdata;
  logic [6:0] q;

  modport bank (input set, input wr, input wdata, output q);
  modport user (output set, output wr, output wdata, input q);
endinterface

// >>> rtl/sticky_flag_bank.sv
// Bank of sticky event flags with hardware set taking priority over software write
`include "pirq_defines.svh"

module sticky_flag_bank (
  input  wire logic   core_clk,
  input  wire logic   nrst,
  sticky_flag_if.bank flags
);

  logic [6:0] q_r;
  logic [6:0] q_nxt;

  // ==========================================================================
  // One flag per bit
  genvar i;
  generate
    for (i = 0; i < `STICKY_COUNT; i = i + 1) begin : g_flag
      always_comb begin
        // An event in the same cycle as a clearing write still lands
        q_nxt[i] = flags.set[i] | (flags.wr[i] ? flags.wdata[i] : q_r[i]);
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q_r <= `RST_STICKY;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign flags.q = q_r;

endmodule

// >>> verif/periph_event_model.sv
// Behavioural model of the peripheral units that raise flag events
module periph_event_model (
  input  wire logic       core_clk,
  output logic            timer_overflow_event,
  output logic            period_match_event,
  output logic            capture_event,
  output logic            compare_match,
  output logic            conv_done_event,
  output logic            osc_fail_event,
  output logic            usb_request,
  output logic            voltage_event,
  output logic            rx_load,
  output logic            tx_buf_free,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Event lines, one-cycle pulses
  logic [9:0] ev_r;
  logic [7:0] rx_r;

  initial begin
    ev_r = 10'h000;
    rx_r = 8'ha5;
  end

  assign {tx_buf_free, rx_load, voltage_event, usb_request, osc_fail_event,
          conv_done_event, compare_match, capture_event, period_match_event,
          timer_overflow_event} = ev_r;
  assign rx_byte = rx_r;

  // Data is valid only beside rx_load; afterwards it is inverted so a stale byte never passes
  task automatic pulse(input logic [9:0] mask);
    @(posedge core_clk);
    ev_r <= mask;
    if (mask[8]) rx_r <= 8'h5a;
    @(posedge core_clk);
    ev_r <= 10'h000;
    if (mask[8]) rx_r <= ~8'h5a;
  endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the peripheral flag registers
`include "pirq_defines.svh"

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pirq_pkg::*;

  typedef struct packed {
    logic [1:0] mode;
    logic [9:0] ev;
    logic [7:0] one;
    logic [7:0] two;
  } row_type;

  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        conv_done_event, rx_load, tx_buf_free, capture_event, compare_match;
  logic        period_match_event, timer_overflow_event, osc_fail_event, usb_request, voltage_event;
  logic [7:0]  rx_byte, tx_byte, flag_reg_one, flag_reg_two;
  logic        tx_pending;
  capcmp_mode_type capcmp_mode;
  logic [31:0] q;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;

  // Event bits: 0 ovf, 1 period, 2 capture, 3 compare, 4 conv, 5 osc, 6 usb, 7 volt, 8 rx, 9 tx
  row_type rows [12] = '{
    '{2'b00, 10'h001, 8'h01, 8'h00}, '{2'b00, 10'h002, 8'h02, 8'h00},
    '{2'b01, 10'h004, 8'h04, 8'h00}, '{2'b11, 10'h008, 8'h04, 8'h00},
    '{2'b10, 10'h00c, 8'h00, 8'h00}, '{2'b00, 10'h00c, 8'h00, 8'h00},
    '{2'b00, 10'h010, 8'h40, 8'h00}, '{2'b00, 10'h020, 8'h00, 8'h80},
    '{2'b00, 10'h040, 8'h00, 8'h20}, '{2'b00, 10'h080, 8'h00, 8'h04},
    '{2'b00, 10'h100, 8'h20, 8'h00}, '{2'b00, 10'h200, 8'h10, 8'h00}};

  always #2 core_clk = ~core_clk;

  // ==========================================================================
  // Design and peripheral model
  periph_irq_flag_regs i_dut (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_done_event(conv_done_event), .rx_load(rx_load), .rx_byte(rx_byte),
    .tx_buf_free(tx_buf_free), .capture_event(capture_event), .compare_match(compare_match),
    .period_match_event(period_match_event), .timer_overflow_event(timer_overflow_event),
    .osc_fail_event(osc_fail_event), .usb_request(usb_request), .voltage_event(voltage_event),
    .tx_byte(tx_byte), .tx_pending(tx_pending), .capcmp_mode(capcmp_mode),
    .flag_reg_one(flag_reg_one), .flag_reg_two(flag_reg_two));

  periph_event_model i_events (
    .core_clk(core_clk), .timer_overflow_event(timer_overflow_event),
    .period_match_event(period_match_event), .capture_event(capture_event),
    .compare_match(compare_match), .conv_done_event(conv_done_event),
    .osc_fail_event(osc_fail_event), .usb_request(usb_request), .voltage_event(voltage_event),
    .rx_load(rx_load), .tx_buf_free(tx_buf_free), .rx_byte(rx_byte));

  // ==========================================================================
  // Bus master, verdict and hang guard
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Inputs are sampled right after the edge, before this edge's updates land
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Side effects of the answer edge land in its update region; compare only once settled
    @(negedge core_clk);
  endtask

  task automatic clear_all;
    bus(1'b1, `OFS_FLAG_ONE, 8'h00, 4'hf, q);
    bus(1'b1, `OFS_FLAG_TWO, 8'h00, 4'hf, q);
    bus(1'b0, `OFS_RX_BUFFER, 8'h00, 4'hf, q);
    bus(1'b1, `OFS_TX_BUFFER, 8'h3c, 4'hf, q);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish;
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      bus(1'b1, `OFS_CAPCMP_CTRL, {6'h00, rows[i].mode}, 4'h1, q);
      `CHK(capcmp_mode, rows[i].mode)
      i_events.pulse(rows[i].ev);
      @(posedge core_clk);
      `CHK(flag_reg_one, rows[i].one)
      `CHK(flag_reg_two, rows[i].two)
      bus(1'b0, `OFS_FLAG_ONE, 8'h00, 4'hf, q);
      `CHK(q, {24'h0, rows[i].one})
      bus(1'b0, `OFS_FLAG_TWO, 8'h00, 4'hf, q);
      `CHK(q, {24'h0, rows[i].two})
      clear_all;
      `CHK({flag_reg_one, flag_reg_two}, 16'h0000)
      $display("Row %0d done", i);
    end

    `CHK({tx_byte, tx_pending}, {8'h3c, 1'b1})
    i_events.pulse(10'h300);
    @(posedge core_clk);
    `CHK({tx_pending, flag_reg_one}, {1'b0, 8'h30})
    bus(1'b0, `OFS_RX_BUFFER, 8'h00, 4'hf, q);
    `CHK(q, 32'h0000_005a)
    `CHK(flag_reg_one, 8'h10)
    clear_all;
    $display("Buffer flags done");

    bus(1'b1, `OFS_FLAG_ONE, 8'hff, 4'hf, q);
    bus(1'b1, `OFS_FLAG_TWO, 8'hff, 4'hf, q);
    bus(1'b0, `OFS_FLAG_ONE, 8'h00, 4'hf, q);
    `CHK(q, 32'h0000_0047)
    bus(1'b0, `OFS_FLAG_TWO, 8'h00, 4'hf, q);
    `CHK(q, 32'h0000_00a4)
    clear_all;
    bus(1'b1, `OFS_FLAG_ONE, 8'hff, 4'h0, q);
    bus(1'b1, 5'h14, 8'hff, 4'hf, q);
    bus(1'b0, 5'h14, 8'h00, 4'hf, q);
    `CHK(q, 32'h0)
    `CHK({flag_reg_one, flag_reg_two}, 16'h0000)
    $display("Unimplemented bits done");

    bus(1'b1, `OFS_FLAG_ONE, 8'h02, 4'hf, q);
    // The event lands on the very edge at which the clearing write takes effect
    fork
      bus(1'b1, `OFS_FLAG_ONE, 8'h00, 4'hf, q);
      begin
        @(posedge core_clk);
        i_events.pulse(10'h001);
      end
    join
    @(posedge core_clk);
    `CHK(flag_reg_one, 8'h01)
    $display("Set against clear done");

    i_events.pulse(10'h0f1);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    `CHK({flag_reg_one, flag_reg_two, avs_waitrequest, avs_readdata}, {16'h0000, 1'b1, 32'h0})
    `CHK({tx_byte, tx_pending, capcmp_mode}, 11'h000)
    nrst <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, `OFS_FLAG_TWO, 8'h00, 4'hf, q);
    `CHK(q, 32'h0)
    $display("Reset done");
    tally_and_finish;
  end
endmodule
